/* File: hdl/wdc_counter.sv */
// Free-running watchdog counter with four selectable count lengths.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/100ps
module wdc_counter import wdc_pkg::*; #(
    parameter int CNT_W = `WDC_LEN_SEL3,
    parameter int LEN0 = 17,
    parameter int LEN1 = 20,
    parameter int LEN2 = 23,
    parameter int LEN3 = `WDC_LEN_SEL3
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_restart,
    input wire logic [1:0] i_sel,
    output logic [CNT_W-1:0] o_count,
    output logic o_timeout
);
    logic [CNT_W-1:0] cnt_q, cnt_d, limit;
    logic tmo_q, tmo_d;
    int len;

    always_comb begin
        case (i_sel)
            2'd0: len = LEN0;
            2'd1: len = LEN1;
            2'd2: len = LEN2;
            default: len = LEN3;
        endcase
        limit = {CNT_W{1'b1}} >> (CNT_W - len);
        tmo_d = 1'b0;
        if (i_restart) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            cnt_d = '0;
            tmo_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
            tmo_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tmo_q <= tmo_d;
        end
    end

    assign o_count = cnt_q;
    assign o_timeout = tmo_q;
endmodule

/* File: hdl/wdc_pkg.sv */
// Types shared by the watchdog control unit modules.
// Assumes wdc_regs.svh is on the include path.
`include "wdc_regs.svh"
package wdc_pkg;
    typedef logic [7:0] wdc_byte_t;
    typedef enum logic {TA_IDLE, TA_ARMED} wdc_ta_e;
    typedef enum logic {DLY_IDLE, DLY_WAIT} wdc_dly_e;
endpackage

/* File: hdl/wdc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// watchdog control unit. Included by the package file and by the bench.
//
// Overview of operation
// - Power-up flag set at power-up, software clears
// - Interrupt flag set on every time-out except during external or watchdog reset, software clears
// - Reset-cause flag set by watchdog reset, sticky
// - Reset enable low: reset-cause flag untouched by watchdog
// - Reset enable arms time-out system reset
// - Restart bit clears counter, then clears itself
// - Time-out: interrupt, then reset 512 clocks later
// - External reset leaves control pattern 0x0x0xx0
// - Reset-cause flag: watchdog sets, power resets clear
// - Power-on sets power-up flag, clears reset enable
// - Protected bits written only inside open window
// - Key AAh then 55h opens three-cycle window
// - Period select 11 gives 26-bit count
// - Priority bit sets watchdog interrupt level
`ifndef WDC_REGS_SVH
`define WDC_REGS_SVH

`define WDC_ADDR_CLOCK_CONTROL 8'h8e
`define WDC_ADDR_TA 8'hc7
`define WDC_ADDR_WATCHDOG_CONTROL_STATUS 8'hd8
`define WDC_ADDR_EIE 8'he8
`define WDC_ADDR_EIP 8'hf8

`define WDC_WATCHDOG_CONTROL_STATUS_POR 6
`define WDC_WATCHDOG_CONTROL_STATUS_WD_INTERRUPT_FLAG 3
`define WDC_WATCHDOG_CONTROL_STATUS_WD_RESET_CAUSE_FLAG 2
`define WDC_WATCHDOG_CONTROL_STATUS_EWT 1
`define WDC_WATCHDOG_CONTROL_STATUS_RWT 0
`define WDC_WATCHDOG_CONTROL_STATUS_FREE_MASK 8'hb0
`define WDC_WATCHDOG_CONTROL_STATUS_KEEP_MASK 8'h10
`define WDC_CLOCK_CONTROL_SEL_HI 7
`define WDC_CLOCK_CONTROL_SEL_LO 6
`define WDC_EIE_WD_IRQ_ENABLE 4
`define WDC_EIP_WD_IRQ_PRIORITY 4
`define WDC_EIE_RSVD_ONES 8'he0

`define WDC_CLOCK_CONTROL_RESET 8'h01
`define WDC_WATCHDOG_CONTROL_STATUS_RESET 8'h40
`define WDC_TA_KEY1 8'haa
`define WDC_TA_KEY2 8'h55

`define WDC_CLK_PERIOD_NS 10
`define WDC_CLKS_PER_MC 4
`define WDC_TA_WINDOW_MC 3
`define WDC_TA_WINDOW_CLKS (`WDC_TA_WINDOW_MC * `WDC_CLKS_PER_MC)
`define WDC_RST_DELAY_CLKS 512
`define WDC_LEN_SEL3 26

`endif

/* File: hdl/wdc_top.sv */
// Watchdog control unit: special function registers, timed access,
// time-out interrupt flag and delayed watchdog system reset.
// Assumes the core's SFR port is on i_clk; reset pins are asynchronous.
`timescale 1ns/100ps
module wdc_top import wdc_pkg::*; #(
    parameter int CNT_W = `WDC_LEN_SEL3,
    parameter int LEN0 = 17,
    parameter int LEN1 = 20,
    parameter int LEN2 = 23,
    parameter int LEN3 = `WDC_LEN_SEL3,
    parameter int RST_DELAY = `WDC_RST_DELAY_CLKS,
    parameter int TA_WINDOW = `WDC_TA_WINDOW_CLKS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ext_rst,
    input wire logic i_pwr_fail,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    output logic [7:0] o_sfr_rdata,
    output logic o_wd_irq,
    output logic o_wd_irq_prio,
    output logic o_wd_reset
);
    localparam int DLY_W = $clog2(RST_DELAY + 1);
    localparam int TA_W = $clog2(TA_WINDOW + 1);

    generate
        if (LEN0 < 1 || LEN1 < 1 || LEN2 < 1 || LEN3 < 1 ||
            LEN0 > CNT_W || LEN1 > CNT_W || LEN2 > CNT_W || LEN3 > CNT_W) begin : g_bad_len
            $error("Watchdog count length outside counter width");
        end
        if (RST_DELAY < 2 || TA_WINDOW < 1) begin : g_bad_dly
            $error("Reset delay or access window too short");
        end
    endgenerate

    // Pin synchronisers
    logic ext_m_q, ext_q, pf_m_q, pf_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_m_q <= 1'b0;
            ext_q <= 1'b0;
            pf_m_q <= 1'b0;
            pf_q <= 1'b0;
        end else begin
            ext_m_q <= i_ext_rst;
            ext_q <= ext_m_q;
            pf_m_q <= i_pwr_fail;
            pf_q <= pf_m_q;
        end
    end

    logic wd_rst_q, wd_rst_d;
    logic soft_rst;
    assign soft_rst = ext_q | wd_rst_q;

    // Address decode
    logic wr_clock_control, wr_ta, wr_watchdog_control_status, wr_eie, wr_eip;
    always_comb begin
        wr_clock_control = 1'b0;
        wr_ta = 1'b0;
        wr_watchdog_control_status = 1'b0;
        wr_eie = 1'b0;
        wr_eip = 1'b0;
        if (!i_sfr_wr) begin
            wr_ta = 1'b0;
        end else if (i_sfr_addr == `WDC_ADDR_CLOCK_CONTROL) begin
            wr_clock_control = 1'b1;
        end else if (i_sfr_addr == `WDC_ADDR_TA) begin
            wr_ta = 1'b1;
        end else if (i_sfr_addr == `WDC_ADDR_WATCHDOG_CONTROL_STATUS) begin
            wr_watchdog_control_status = 1'b1;
        end else if (i_sfr_addr == `WDC_ADDR_EIE) begin
            wr_eie = 1'b1;
        end else if (i_sfr_addr == `WDC_ADDR_EIP) begin
            wr_eip = 1'b1;
        end
    end

    // Timed access key sequence and window
    wdc_ta_e ta_st_q, ta_st_d;
    logic [TA_W-1:0] ta_cnt_q, ta_cnt_d;
    logic ta_open;
    assign ta_open = (ta_cnt_q != '0);

    always_comb begin
        ta_st_d = ta_st_q;
        ta_cnt_d = ta_cnt_q;
        if (ta_cnt_q != '0) begin
            ta_cnt_d = ta_cnt_q - 1'b1;
        end
        if (soft_rst) begin
            ta_st_d = TA_IDLE;
            ta_cnt_d = '0;
        end else if (i_sfr_wr) begin
            case (ta_st_q)
                TA_IDLE: begin
                    if (wr_ta && i_sfr_wdata == `WDC_TA_KEY1) begin
                        ta_st_d = TA_ARMED;
                    end
                end
                default: begin
                    ta_st_d = TA_IDLE;
                    if (wr_ta && i_sfr_wdata == `WDC_TA_KEY2) begin
                        ta_cnt_d = TA_W'(TA_WINDOW);
                    end else if (wr_ta && i_sfr_wdata == `WDC_TA_KEY1) begin
                        ta_st_d = TA_ARMED;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ta_st_q <= TA_IDLE;
            ta_cnt_q <= '0;
        end else begin
            ta_st_q <= ta_st_d;
            ta_cnt_q <= ta_cnt_d;
        end
    end

    // Watchdog control and companion registers
    logic por_q, por_d, ewt_q, ewt_d, wd_interrupt_flag_q, wd_interrupt_flag_d, wd_reset_cause_flag_q, wd_reset_cause_flag_d, rwt_q, rwt_d;
    logic [2:0] free_q, free_d;
    wdc_byte_t clock_control_q, clock_control_d;
    logic wd_irq_enable_q, wd_irq_enable_d, wd_irq_priority_q, wd_irq_priority_d;
    logic prot_wr;
    logic timeout;
    logic [CNT_W-1:0] wd_count;
    assign prot_wr = wr_watchdog_control_status && ta_open;

    always_comb begin
        por_d = por_q;
        ewt_d = ewt_q;
        wd_interrupt_flag_d = wd_interrupt_flag_q;
        wd_reset_cause_flag_d = wd_reset_cause_flag_q;
        rwt_d = 1'b0;
        free_d = free_q;
        clock_control_d = clock_control_q;
        wd_irq_enable_d = wd_irq_enable_q;
        wd_irq_priority_d = wd_irq_priority_q;
        if (prot_wr) begin
            por_d = i_sfr_wdata[`WDC_WATCHDOG_CONTROL_STATUS_POR];
            ewt_d = i_sfr_wdata[`WDC_WATCHDOG_CONTROL_STATUS_EWT];
        end
        if (soft_rst) begin
            wd_interrupt_flag_d = 1'b0;
            free_d = {1'b0, 1'b0, free_q[0]};
            clock_control_d = `WDC_CLOCK_CONTROL_RESET;
            wd_irq_enable_d = 1'b0;
            wd_irq_priority_d = 1'b0;
        end else begin
            if (timeout) begin
                wd_interrupt_flag_d = 1'b1;
            end else if (prot_wr) begin
                wd_interrupt_flag_d = i_sfr_wdata[`WDC_WATCHDOG_CONTROL_STATUS_WD_INTERRUPT_FLAG];
            end
            if (prot_wr && i_sfr_wdata[`WDC_WATCHDOG_CONTROL_STATUS_RWT]) begin
                rwt_d = 1'b1;
            end
            if (wr_watchdog_control_status) begin
                free_d = {i_sfr_wdata[7], i_sfr_wdata[5], i_sfr_wdata[4]};
            end
            if (wr_clock_control) begin
                clock_control_d = i_sfr_wdata;
            end
            if (wr_eie) begin
                wd_irq_enable_d = i_sfr_wdata[`WDC_EIE_WD_IRQ_ENABLE];
            end
            if (wr_eip) begin
                wd_irq_priority_d = i_sfr_wdata[`WDC_EIP_WD_IRQ_PRIORITY];
            end
        end
        if (wd_rst_q && ewt_q) begin
            wd_reset_cause_flag_d = 1'b1;
        end else if (pf_q) begin
            wd_reset_cause_flag_d = 1'b0;
        end else if (wr_watchdog_control_status) begin
            wd_reset_cause_flag_d = i_sfr_wdata[`WDC_WATCHDOG_CONTROL_STATUS_WD_RESET_CAUSE_FLAG];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            por_q <= 1'b1;
            ewt_q <= 1'b0;
            wd_interrupt_flag_q <= 1'b0;
            wd_reset_cause_flag_q <= 1'b0;
            rwt_q <= 1'b0;
            free_q <= '0;
            clock_control_q <= `WDC_CLOCK_CONTROL_RESET;
            wd_irq_enable_q <= 1'b0;
            wd_irq_priority_q <= 1'b0;
        end else begin
            por_q <= por_d;
            ewt_q <= ewt_d;
            wd_interrupt_flag_q <= wd_interrupt_flag_d;
            wd_reset_cause_flag_q <= wd_reset_cause_flag_d;
            rwt_q <= rwt_d;
            free_q <= free_d;
            clock_control_q <= clock_control_d;
            wd_irq_enable_q <= wd_irq_enable_d;
            wd_irq_priority_q <= wd_irq_priority_d;
        end
    end

    wdc_counter #(
        .CNT_W(CNT_W),
        .LEN0(LEN0),
        .LEN1(LEN1),
        .LEN2(LEN2),
        .LEN3(LEN3)
    ) u_counter (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(rwt_q | soft_rst),
        .i_sel(clock_control_q[`WDC_CLOCK_CONTROL_SEL_HI:`WDC_CLOCK_CONTROL_SEL_LO]),
        .o_count(wd_count),
        .o_timeout(timeout)
    );

    // Delay from time-out to watchdog reset
    wdc_dly_e dly_st_q, dly_st_d;
    logic [DLY_W-1:0] dly_cnt_q, dly_cnt_d;

    always_comb begin
        dly_st_d = dly_st_q;
        dly_cnt_d = dly_cnt_q;
        wd_rst_d = 1'b0;
        if (soft_rst || rwt_q) begin
            dly_st_d = DLY_IDLE;
            dly_cnt_d = '0;
        end else begin
            case (dly_st_q)
                DLY_IDLE: begin
                    if (timeout) begin
                        dly_st_d = DLY_WAIT;
                        dly_cnt_d = DLY_W'(RST_DELAY - 1);
                    end
                end
                default: begin
                    dly_cnt_d = dly_cnt_q - 1'b1;
                    if (dly_cnt_q == DLY_W'(1)) begin
                        dly_st_d = DLY_IDLE;
                        wd_rst_d = ewt_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dly_st_q <= DLY_IDLE;
            dly_cnt_q <= '0;
            wd_rst_q <= 1'b0;
        end else begin
            dly_st_q <= dly_st_d;
            dly_cnt_q <= dly_cnt_d;
            wd_rst_q <= wd_rst_d;
        end
    end

    // Read-back, answered the cycle after the read strobe
    wdc_byte_t rdata_q, rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (!i_sfr_rd) begin
            rdata_d = rdata_q;
        end else if (i_sfr_addr == `WDC_ADDR_CLOCK_CONTROL) begin
            rdata_d = clock_control_q;
        end else if (i_sfr_addr == `WDC_ADDR_WATCHDOG_CONTROL_STATUS) begin
            rdata_d = {free_q[2], por_q, free_q[1], free_q[0], wd_interrupt_flag_q, wd_reset_cause_flag_q, ewt_q, rwt_q};
        end else if (i_sfr_addr == `WDC_ADDR_EIE) begin
            rdata_d = `WDC_EIE_RSVD_ONES | {3'h0, wd_irq_enable_q, 4'h0};
        end else if (i_sfr_addr == `WDC_ADDR_EIP) begin
            rdata_d = {3'h0, wd_irq_priority_q, 4'h0};
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_sfr_rdata = rdata_q;
    assign o_wd_irq = wd_interrupt_flag_q & wd_irq_enable_q;
    assign o_wd_irq_prio = wd_irq_priority_q;
    assign o_wd_reset = wd_rst_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Key bytes one idle cycle apart, as the core's write strobes arrive
    sequence s_key;
        wr_ta && i_sfr_wdata == `WDC_TA_KEY1 && !soft_rst
        ##1 !i_sfr_wr && !soft_rst
        ##1 wr_ta && i_sfr_wdata == `WDC_TA_KEY2 && !soft_rst;
    endsequence
    sequence s_timeout_run;
        timeout && !soft_rst && !rwt_q ##1 (!soft_rst && !rwt_q)[*8];
    endsequence

    property p_ta_window;
        s_key |=> ta_open[*8];
    endproperty
    a_ta_window: assert property (p_ta_window) else $error("Access window not open");

    property p_protect;
        wr_watchdog_control_status && !ta_open |=> ewt_q == $past(ewt_q) && por_q == $past(por_q);
    endproperty
    a_protect: assert property (p_protect) else $error("Protected bit written");

    property p_rwt_clear;
        rwt_q |=> !rwt_q && wd_count == '0;
    endproperty
    a_rwt_clear: assert property (p_rwt_clear) else $error("Restart did not clear");

    property p_wd_interrupt_flag_set;
        timeout && !soft_rst |=> wd_interrupt_flag_q;
    endproperty
    a_wd_interrupt_flag_set: assert property (p_wd_interrupt_flag_set) else $error("Time-out flag not set");

    property p_delay_armed;
        s_timeout_run |-> dly_st_q == DLY_WAIT && !o_wd_reset;
    endproperty
    a_delay_armed: assert property (p_delay_armed) else $error("Reset came early");

    property p_reset_fires;
        dly_st_q == DLY_WAIT && dly_cnt_q == DLY_W'(1) && ewt_q && !soft_rst && !rwt_q
        |=> o_wd_reset ##1 wd_reset_cause_flag_q;
    endproperty
    a_reset_fires: assert property (p_reset_fires) else $error("Watchdog reset missing");

    property p_no_ewt_no_wd_reset_cause_flag;
        !ewt_q && !wr_watchdog_control_status |=> !$rose(wd_reset_cause_flag_q);
    endproperty
    a_no_ewt_no_wd_reset_cause_flag: assert property (p_no_ewt_no_wd_reset_cause_flag) else $error("Cause flag moved");

    property p_ext_pattern;
        ext_q && !wr_watchdog_control_status && !pf_q && !wd_rst_q
        |=> !wd_interrupt_flag_q && !rwt_q && $stable(ewt_q) && $stable(por_q) && $stable(wd_reset_cause_flag_q);
    endproperty
    a_ext_pattern: assert property (p_ext_pattern) else $error("External reset pattern");

    property p_pf_clear;
        pf_q && !(wd_rst_q && ewt_q) |=> !wd_reset_cause_flag_q;
    endproperty
    a_pf_clear: assert property (p_pf_clear) else $error("Power reset kept flag");

    property p_irq;
        timeout && wd_irq_enable_q && !soft_rst && !wr_eie |=> o_wd_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt request wrong");
endmodule

/* File: tb/wdc_top_bench.sv */
// Self-checking bench for the watchdog control unit top level.
// Assumes wdc_regs.svh is on the include path and wdc_pkg is compiled first.
`timescale 1ns/100ps
`include "wdc_regs.svh"

`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module wdc_top_bench import wdc_pkg::*;;
    logic clk = 1'b0;
    logic nrst;
    logic ext_rst;
    logic pwr_fail;
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic rd;
    logic [7:0] rdata;
    logic irq;
    logic prio;
    logic wdrst;
    logic rd_q = 1'b0;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int seed = 89;
    int cnt;
    int lens[4] = '{4, 5, 6, 8};
    wdc_byte_t exp_q[$];
    wdc_byte_t e;
    wdc_byte_t r;

    always #5 clk = ~clk;

    // Short count lengths keep every period well inside the run
    wdc_top #(.CNT_W(8), .LEN0(4), .LEN1(5), .LEN2(6), .LEN3(8)) u_dut (
        .i_clk(clk),
        .i_nrst(nrst),
        .i_ext_rst(ext_rst),
        .i_pwr_fail(pwr_fail),
        .i_sfr_addr(addr),
        .i_sfr_wr(wr),
        .i_sfr_wdata(wdata),
        .i_sfr_rd(rd),
        .o_sfr_rdata(rdata),
        .o_wd_irq(irq),
        .o_wd_irq_prio(prio),
        .o_wd_reset(wdrst)
    );

    task automatic wr_sfr(input wdc_byte_t a, input wdc_byte_t d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask

    // Notes the expected byte, the monitor compares it one cycle later
    task automatic rd_sfr(input wdc_byte_t a, input wdc_byte_t d);
        exp_q.push_back(d);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
    endtask

    task automatic unlock();
        wr_sfr(`WDC_ADDR_TA, `WDC_TA_KEY1);
        wr_sfr(`WDC_ADDR_TA, `WDC_TA_KEY2);
    endtask

    task automatic wait_irq();
        cnt = 0;
        while (irq !== 1'b1 && cnt < 400) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        rd_q <= rd && nrst;
    end

    always @(negedge clk) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            `CHK(rdata, e)
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            $display("ERROR %0t: run exceeded cycle limit", $time);
            give_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        ext_rst = 1'b0;
        pwr_fail = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
        rd = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        // Reset values; longest period chosen early to keep flags quiet
        rd_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'h01);
        wr_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'hc1);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h40);
        rd_sfr(`WDC_ADDR_EIE, 8'he0);
        rd_sfr(`WDC_ADDR_EIP, 8'h00);
        rd_sfr(`WDC_ADDR_TA, 8'h00);
        wr_sfr(8'h80, 8'hff);
        rd_sfr(8'h80, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, r & 8'hfb);
            rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, (r & 8'hb0) | 8'h40);
            wr_sfr(`WDC_ADDR_CLOCK_CONTROL, r | 8'hc0);
            rd_sfr(`WDC_ADDR_CLOCK_CONTROL, r | 8'hc0);
        end
        wr_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'hc1);
        wr_sfr(`WDC_ADDR_TA, `WDC_TA_KEY2);
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h40);
        unlock();
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        unlock();
        repeat (14) @(negedge clk);
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h42);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        unlock();
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h01);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        $display("test timed access done");
        wr_sfr(`WDC_ADDR_EIE, 8'hff);
        rd_sfr(`WDC_ADDR_EIE, 8'hf0);
        wr_sfr(`WDC_ADDR_EIP, 8'hff);
        rd_sfr(`WDC_ADDR_EIP, 8'h10);
        `CHK(prio, 1'b1)
        wr_sfr(`WDC_ADDR_EIP, 8'h00);
        `CHK(prio, 1'b0)
        $display("test interrupt bits done");
        for (int s = 0; s < 4; s++) begin
            // Restart, change period, then restart and clear the flag again
            unlock();
            wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h01);
            wr_sfr(`WDC_ADDR_CLOCK_CONTROL, {s[1:0], 6'h01});
            wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h01);
            wait_irq();
            `CHK(cnt inside {[(1 << lens[s]):(1 << lens[s]) + 2]}, 1'b1)
        end
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h08);
        wr_sfr(`WDC_ADDR_EIE, 8'h00);
        `CHK(irq, 1'b0)
        wr_sfr(`WDC_ADDR_EIE, 8'hff);
        `CHK(irq, 1'b1)
        $display("test periods done");
        unlock();
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h03);
        wait_irq();
        cnt = 0;
        while (wdrst !== 1'b1 && cnt < 600) begin
            @(negedge clk);
            cnt++;
        end
        `CHK(cnt, `WDC_RST_DELAY_CLKS - 1)
        @(negedge clk);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h06);
        wr_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'hc1);
        $display("test watchdog reset done");
        unlock();
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'hf6);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'hf6);
        ext_rst = 1'b1;
        repeat (4) @(negedge clk);
        ext_rst = 1'b0;
        repeat (3) @(negedge clk);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h56);
        rd_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'h01);
        wr_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'hc1);
        unlock();
        wr_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h05);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h04);
        pwr_fail = 1'b1;
        repeat (4) @(negedge clk);
        pwr_fail = 1'b0;
        repeat (3) @(negedge clk);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
        $display("test external and power-fail resets done");
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        rd_sfr(`WDC_ADDR_WATCHDOG_CONTROL_STATUS, 8'h40);
        rd_sfr(`WDC_ADDR_CLOCK_CONTROL, 8'h01);
        $display("test power-on reset done");
        give_verdict();
    end
endmodule
